// File: snx_pkg.sv
// Operation
// - strobe fall latches code from nibble port
// - host samples nibble, then raises strobe
// - write data presented around strobe rise
// - host waits 50 ms after power-up
// - dummy read before turning output to input
package snx_pkg;
    localparam int unsigned CLK_MHZ = 125;
    localparam int unsigned T_POWERUP_MS = 50;
    localparam int unsigned T_SETUP_NS = 200;
    localparam int unsigned T_HOLD_NS = 100;
    localparam int unsigned T_LOW_NS = 700;
    localparam int unsigned T_SAMPLE_NS = 650;
    localparam int unsigned T_CS_NS = 50;
    localparam int unsigned N_SETUP = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned N_HOLD = (T_HOLD_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned N_LOW = (T_LOW_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned N_SAMPLE = (T_SAMPLE_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned N_CS = (T_CS_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned N_POWERUP = T_POWERUP_MS * CLK_MHZ * 1000;
    localparam logic [31:0] N_POWERUP_W = 32'(N_POWERUP);
    localparam logic [15:0] CNT_SETUP = 16'(N_SETUP);
    localparam logic [15:0] CNT_HOLD = 16'(N_HOLD);
    localparam logic [15:0] CNT_LOW = 16'(N_LOW);
    localparam logic [15:0] CNT_SAMPLE = 16'(N_SAMPLE);
    localparam logic [15:0] CNT_CS = 16'(N_CS);
    // register byte addresses
    localparam logic [11:0] ADDR_CMD = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_RDATA = 12'h008;
    // command word fields
    localparam int unsigned CMD_PORT_LSB = 0;
    localparam int unsigned CMD_OP_LSB = 2;
    localparam int unsigned CMD_DATA_LSB = 4;
    localparam int unsigned CMD_DUMMY_BIT = 8;
    // status bits
    localparam int unsigned ST_BUSY = 0;
    localparam int unsigned ST_READY = 1;
    localparam int unsigned ST_DONE = 2;
    localparam logic [1:0] OP_READ = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_OR = 2'h2;
    localparam logic [1:0] OP_AND = 2'h3;
    typedef struct packed {
        logic prog_n;
        logic cs_n;
        logic [3:0] nib_o;
        logic [3:0] nib_oe_n;
    } snx_link_out_t;
endpackage

// File: snx_host.sv
// Register access over APB and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
module snx_host #(
    parameter logic [31:0] POWERUP_CYCLES = snx_pkg::N_POWERUP_W
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // expander link
    output snx_pkg::snx_link_out_t link_o,
    input wire logic [3:0] control_nibble_port_i
);
    import snx_pkg::*;

    typedef enum logic [5:0] {
        S_WAIT = 6'h01,
        S_IDLE = 6'h02,
        S_SETUP = 6'h04,
        S_LOW = 6'h08,
        S_DATA = 6'h10,
        S_HOLD = 6'h20
    } snx_state_t;

    snx_state_t state_q, state_d;
    logic [31:0] pwr_q;
    logic [15:0] cnt_q;
    logic [1:0] op_q;
    logic [1:0] port_q;
    logic [3:0] data_q;
    logic dummy_q;
    logic done_q;
    logic [3:0] rdata_q;
    logic [3:0] sync1_q, sync2_q;
    snx_link_out_t link_q;
    logic [31:0] prdata_q;
    logic pslverr_q;
    logic pready_q;

    wire logic acc = psel && penable;
    wire logic hit_cmd = paddr == ADDR_CMD;
    wire logic hit_st = paddr == ADDR_STATUS;
    wire logic hit_rd = paddr == ADDR_RDATA;
    wire logic mapped = hit_cmd || hit_st || hit_rd;
    wire logic busy = state_q != S_IDLE;
    wire logic start = acc && pwrite && hit_cmd && !busy;
    wire logic cnt_end = cnt_q == 16'h0000;
    wire logic is_read = op_q == OP_READ;
    wire logic [31:0] status_w = {29'h0, done_q, state_q == S_IDLE, busy};
    wire logic [31:0] rd_mux = hit_st ? status_w : hit_rd ? {28'h0, rdata_q} : 32'h0;
    wire logic wr_err = pwrite && (!hit_cmd || busy);
    wire logic err_w = !mapped || wr_err;

    // sequencer: code, strobe low, data, strobe high
    always_comb begin
        state_d = state_q;
        case (state_q)
            S_WAIT: if (pwr_q == 32'h0) state_d = S_IDLE;
            S_IDLE: if (start) state_d = S_SETUP;
            S_SETUP: if (cnt_end) state_d = S_LOW;
            S_LOW: if (cnt_end) state_d = S_DATA;
            S_DATA: if (cnt_end) state_d = S_HOLD;
            S_HOLD: if (cnt_end) state_d = dummy_q ? S_SETUP : S_IDLE;
            default: state_d = S_IDLE;
        endcase
    end

    // counter reload per phase
    logic [15:0] cnt_d;
    always_comb begin
        cnt_d = cnt_q - 16'h1;
        if (state_q != state_d) begin
            case (state_d)
                S_SETUP: cnt_d = CNT_SETUP;
                S_LOW: cnt_d = is_read ? CNT_SAMPLE : CNT_LOW - CNT_SETUP;
                S_DATA: cnt_d = CNT_SETUP;
                S_HOLD: cnt_d = CNT_HOLD + CNT_CS;
                default: cnt_d = 16'h0;
            endcase
        end else if (cnt_end) begin
            cnt_d = 16'h0;
        end
    end

    // the start edge shows the new command, not the previous one, on the lines
    wire logic [3:0] code_w = (state_q == S_IDLE) ?
        {pwdata[CMD_OP_LSB +: 2], pwdata[CMD_PORT_LSB +: 2]} : {op_q, port_q};
    // code still held after the fall; the expander only answers once it is released
    wire logic code_gone = cnt_d <= CNT_SAMPLE - CNT_HOLD;

    // link drive: code before fall, data around rise, released during read
    snx_link_out_t link_d;
    always_comb begin
        link_d.cs_n = !(state_q inside {S_SETUP, S_LOW, S_DATA, S_HOLD});
        link_d.prog_n = !(state_d inside {S_LOW, S_DATA}) || state_q == S_IDLE;
        link_d.nib_o = 4'h0;
        link_d.nib_oe_n = 4'hF;
        case (state_d)
            S_SETUP: begin
                link_d.nib_o = code_w;
                link_d.nib_oe_n = 4'h0;
            end
            S_LOW: begin
                link_d.nib_o = {op_q, port_q};
                link_d.nib_oe_n = (is_read && code_gone) ? 4'hF : 4'h0;
            end
            S_DATA, S_HOLD: begin
                link_d.nib_o = data_q;
                link_d.nib_oe_n = is_read ? 4'hF : 4'h0;
            end
            default: begin
                link_d.nib_o = 4'h0;
            end
        endcase
        if (state_q == S_IDLE && state_d == S_SETUP) begin
            link_d.cs_n = 1'b0;
        end
    end

    // phase state and per-phase counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= S_WAIT;
            cnt_q <= 16'h0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    // reset loads the full wait, so no command reaches the link too early
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwr_q <= POWERUP_CYCLES;
        end else if (state_q == S_WAIT && pwr_q != 32'h0) begin
            pwr_q <= pwr_q - 32'h1;
        end else begin
            pwr_q <= 32'h0;
        end
    end

    // link pins straight from flops, so they never glitch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link_q <= '{prog_n: 1'b1, cs_n: 1'b1, nib_o: 4'h0, nib_oe_n: 4'hF};
        end else begin
            link_q <= link_d;
        end
    end

    // command capture; dummy read is cleared after its first pass
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_q <= OP_READ;
            port_q <= 2'h0;
            data_q <= 4'h0;
            dummy_q <= 1'b0;
        end else if (start) begin
            port_q <= pwdata[CMD_PORT_LSB +: 2];
            op_q <= pwdata[CMD_OP_LSB +: 2];
            data_q <= pwdata[CMD_DATA_LSB +: 4];
            dummy_q <= pwdata[CMD_DUMMY_BIT] && pwdata[CMD_OP_LSB +: 2] == OP_READ;
        end else if (state_q == S_HOLD && cnt_end) begin
            dummy_q <= 1'b0;
        end
    end

    // two-stage synchroniser on the nibble pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
        end else begin
            sync1_q <= control_nibble_port_i;
            sync2_q <= sync1_q;
        end
    end

    // sample late in the low time, well past the expander's access time
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= 4'h0;
            done_q <= 1'b0;
        end else begin
            if (state_q == S_DATA && cnt_end && is_read) begin
                rdata_q <= sync2_q;
            end
            if (state_q == S_HOLD && cnt_end && !dummy_q) begin
                done_q <= 1'b1;
            end else if (start) begin
                done_q <= 1'b0;
            end
        end
    end

    // response taken from the setup cycle, so no wait states are needed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0;
            pslverr_q <= 1'b0;
            pready_q <= 1'b0;
        end else begin
            prdata_q <= (psel && !penable && !pwrite) ? rd_mux : prdata_q;
            pslverr_q <= psel && !penable && err_w;
            pready_q <= 1'b1;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign link_o = link_q;
endmodule

// File: snx_host_assertions.sv
`timescale 1ns/10ps
module snx_host_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pslverr,
    input wire snx_pkg::snx_link_out_t link_o
);
    import snx_pkg::*;
    wire p = link_o.prog_n;
    wire c = link_o.cs_n;
    wire [3:0] oe = link_o.nib_oe_n;
    wire [3:0] d = link_o.nib_o;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_code_setup: assert property ($fell(p) |-> !c && $past(oe, 13) == 4'h0 && $past(d, 13) == d)
        else $error("code not set up at strobe fall");
    a_code_hold: assert property ($fell(p) |-> (oe == 4'h0 && $stable(d))[*8])
        else $error("code not held after strobe fall");
    a_cs_idle: assert property (c |-> p)
        else $error("strobe low while deselected");
    a_low_width: assert property ($rose(p) |-> $past(p, 88) == 1'b0)
        else $error("strobe low too short");
    a_wdata_setup: assert property ($rose(p) && oe == 4'h0 |-> $past(d, 25) == d)
        else $error("write data not set up");
    a_wdata_hold: assert property ($rose(p) && oe == 4'h0 |=> (oe == 4'h0 && $stable(d))[*2])
        else $error("write data not held");
    a_cs_at_rise: assert property ($rose(p) |-> $past(c) == 1'b0)
        else $error("select dropped before strobe rise");
    cover property ($rose(p) && oe == 4'h0);
    cover property ($rose(p) && oe == 4'hF);
    cover property (pslverr);
endmodule
bind snx_host snx_host_checker u_chk (.pclk(pclk), .presetn(presetn), .pslverr(pslverr),
    .link_o(link_o));

// File: snx_expander_model.sv
`timescale 1ns/10ps
module snx_expander_model (
    input wire logic prog_n,
    input wire logic cs_n,
    input wire logic [3:0] nib,
    input wire logic [15:0] ext,
    output logic drv_en,
    output logic [3:0] drv,
    output logic [15:0] pins,
    output logic [3:0] mode
);
    logic [3:0] code;
    logic [3:0] lat [4];
    // an output port is not yet tri-stated on the first read that turns it around
    logic stale;
    initial stale = 1'b0;
    // deselect masks the strobe entirely
    wire strobe = prog_n | cs_n;
    wire [1:0] sel = code[1:0];
    initial mode = 4'h0;
    initial drv_en = 1'b0;
    always_comb for (int i = 0; i < 4; i++) pins[4*i+:4] = mode[i] ? lat[i] : ext[4*i+:4];
    assign drv = stale ? lat[sel] : pins[4*sel+:4];
    always @(negedge strobe) begin
        code = nib;
        if (nib[3:2] == 2'h0) begin
            stale = mode[nib[1:0]];
            mode[nib[1:0]] = 1'b0;
            drv_en = 1'b1;
        end
    end
    always @(posedge strobe) begin
        drv_en = 1'b0;
        stale = 1'b0;
        case (code[3:2])
            2'h1: lat[sel] = nib;
            2'h2: lat[sel] = lat[sel] | nib;
            2'h3: lat[sel] = lat[sel] & nib;
            default: ;
        endcase
        if (code[3:2] != 2'h0) mode[sel] = 1'b1;
    end
endmodule

// File: test_snx_host.sv
`timescale 1ns/10ps
module test_snx_host;
    import snx_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, drv_en, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    snx_link_out_t link_o;
    logic [3:0] nib, last, drv, mode;
    logic [15:0] ext, pins;
    int n_mismatch = 0, check_count = 0, i, n;
    // released lines show the expander's drive when it is enabled, otherwise the inverse of their last level
    assign nib = (~link_o.nib_oe_n & link_o.nib_o) | (link_o.nib_oe_n & (drv_en ? drv : ~last));
    always @(posedge pclk) last <= nib;
    snx_host #(.POWERUP_CYCLES(32'h0000_0100)) u_snx_host (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .link_o(link_o),
        .control_nibble_port_i(nib));
    snx_expander_model u_snx_expander_model (.prog_n(link_o.prog_n), .cs_n(link_o.cs_n),
        .nib(nib), .ext(ext), .drv_en(drv_en), .drv(drv), .pins(pins), .mode(mode));
    task chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s exp %h seen %h", s, exp, seen);
        end
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) n_mismatch++;
        if (n >= 50) finish_test;
        @(posedge pclk);
    endtask
    // polls a status bit, the only safe gate for the next command
    task wait_bit(input int b);
        i = 0;
        do apb(1'b0, ADDR_STATUS, 32'h0); while (r[b] !== 1'b1 && ++i < 500);
        if (i >= 500) n_mismatch++;
        if (i >= 500) finish_test;
    endtask
    task op(input logic [1:0] p, input logic [1:0] o, input logic [3:0] d, input logic dm);
        apb(1'b1, ADDR_CMD, {23'h0, dm, d, o, p});
        chk("cmd err", {31'h0, e}, 32'h0);
        wait_bit(ST_DONE);
    endtask
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, last} = '0;
        ext = 16'hA5C3;
        repeat (2) @(posedge pclk);
        chk("idle link", {22'h0, link_o}, {22'h0, 10'h30F});
        chk("power mode", {28'h0, mode}, 32'h0);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk("power wait", {31'h0, r[ST_READY]}, 32'h0);
        apb(1'b1, ADDR_CMD, 32'h0000_0017);
        chk("early cmd", {31'h0, e}, 32'h1);
        wait_bit(ST_READY);
        for (int k = 0; k < 4; k++) begin
            op(k[1:0], OP_WRITE, 4'h9 ^ k[3:0], 1'b0);
            chk("mode", {28'h0, mode}, (32'h2 << k) - 1);
        end
        chk("pins", {16'h0, pins}, 32'hAB89);
        $display("write test done");
        op(2'h1, OP_OR, 4'h5, 1'b0);
        chk("or", {28'h0, pins[7:4]}, 32'hD);
        op(2'h1, OP_AND, 4'h6, 1'b0);
        chk("and", {28'h0, pins[7:4]}, 32'h4);
        $display("and/or test done");
        op(2'h0, OP_READ, 4'h0, 1'b1);
        apb(1'b0, ADDR_RDATA, 32'h0);
        chk("read", {28'h0, r[3:0]}, 32'h3);
        chk("read mode", {28'h0, mode}, 32'hE);
        ext = 16'hA5C6;
        op(2'h0, OP_READ, 4'h0, 1'b0);
        apb(1'b0, ADDR_RDATA, 32'h0);
        chk("reread", {28'h0, r[3:0]}, 32'h6);
        $display("read test done");
        apb(1'b1, ADDR_CMD, {26'h0, OP_WRITE, 2'h3} | 32'h0);
        apb(1'b1, ADDR_CMD, 32'h00F7);
        chk("busy err", {31'h0, e}, 32'h1);
        wait_bit(ST_DONE);
        chk("port d", {28'h0, pins[15:12]}, 32'h0);
        apb(1'b0, 12'h00C, 32'h0);
        chk("bad addr", {31'h0, e}, 32'h1);
        $display("refusal test done");
        finish_test;
    end
endmodule
